/* logic/tfl_fault_los.sv */
// Laser fault latch, transmit disable and signal-loss status with status byte
//
// Behaviour
// - Laser fault raises fault output, laser off
// - Fault output low normally, high on fault
// - Fault stays latched after cause disappears
// - Only disable pin toggle or power cycle clears; a software disable toggle does not
// - Fault mirrored in status byte bit 2
// - Eye-safety unsafe condition disables transmitter
// - Signal-lost output high when input unusable
// - Signal-lost mirrored in status byte bit 1
// - Disable high turns transmitter off
// - Software disable bit ORed with pin
// - Undriven disable input counts as asserted
`timescale 1ns/1ps

module tfl_fault_los
    import tfl_pkg::*;
(
    // Clock and reset (reset stands for power cycling)
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // Host control pin
    input  wire logic       tx_disable_in,
    input  wire logic       tx_disable_driven_in,
    // Internal monitors
    input  wire logic       laser_fault_in,
    input  wire logic       eye_unsafe_in,
    input  wire logic       rx_unusable_in,
    // Status byte access from the serial interface
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Host status pins (fault pin is open drain)
    output logic            tx_fault_out,
    output logic            tx_fault_oe_out,
    output logic            optical_signal_lost_out,
    // Laser driver
    output logic            laser_enable_out
);

    // ------------------------------------------------------------
    // Effective disable level
    // ------------------------------------------------------------
    logic pin_dis;
    logic any_dis;
    logic soft_dis_ff;
    logic nxt_soft_dis;

    assign pin_dis = tx_disable_in | ~tx_disable_driven_in;
    assign any_dis = pin_dis | soft_dis_ff;

    function automatic logic hits_ctl(input logic [7:0] addr);
        hits_ctl = (addr == TFL_CTL_STATUS_OFS);
    endfunction : hits_ctl

    assign nxt_soft_dis = (reg_wr_in && hits_ctl(reg_addr_in)) ?
                          reg_wdata_in[TFL_BIT_SOFT_DIS] : soft_dis_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            soft_dis_ff <= TFL_SOFT_DIS_RST;
        end else begin
            soft_dis_ff <= nxt_soft_dis;
        end
    end

    // ------------------------------------------------------------
    // Fault latch and clearing toggle
    // ------------------------------------------------------------
    logic fault_ff;
    logic nxt_fault;
    logic seen_high_ff;
    logic nxt_seen_high;
    logic release_evt;
    logic fault_cause;

    assign fault_cause = laser_fault_in | eye_unsafe_in;
    assign release_evt = seen_high_ff & ~pin_dis;
    // Set wins over the release so a persisting fault stays latched
    assign nxt_fault     = fault_cause | (fault_ff & ~release_evt);
    assign nxt_seen_high = fault_ff & (pin_dis | (seen_high_ff & ~release_evt));

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_high_ff <= 1'b0;
        end else begin
            seen_high_ff <= nxt_seen_high;
        end
    end

    // ------------------------------------------------------------
    // Laser enable and status pins
    // ------------------------------------------------------------
    logic laser_en_ff;
    logic los_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            laser_en_ff <= 1'b0;
        end else begin
            laser_en_ff <= ~(nxt_fault | eye_unsafe_in | pin_dis | nxt_soft_dis);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            los_ff <= 1'b0;
        end else begin
            los_ff <= rx_unusable_in;
        end
    end

    assign laser_enable_out        = laser_en_ff;
    assign tx_fault_out            = 1'b0;
    // Drive low while healthy, release to the pull-up on fault
    assign tx_fault_oe_out         = ~fault_ff;
    assign optical_signal_lost_out = los_ff;

    // ------------------------------------------------------------
    // Status byte read
    // ------------------------------------------------------------
    tfl_ctl_status_s status;
    logic [7:0]      rdata_ff;

    always_comb begin
        status           = '0;
        status.dis_state = any_dis;
        status.soft_dis  = soft_dis_ff;
        status.tx_fault  = fault_ff;
        status.sig_lost  = los_ff;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= TFL_RDATA_UNMAPPED;
        end else if (hits_ctl(reg_addr_in)) begin
            rdata_ff <= status;
        end else begin
            rdata_ff <= TFL_RDATA_UNMAPPED;
        end
    end

    assign reg_rdata_out = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_fault_latched;
        fault_ff && pin_dis;
    endsequence

    sequence s_pin_released;
        !pin_dis && !fault_cause;
    endsequence

    AST_FAULT_SETS: assert property (laser_fault_in |=> fault_ff && !laser_en_ff)
        else $error("laser fault did not latch and stop the laser");

    AST_PIN_LEVEL: assert property (fault_cause |=> !tx_fault_oe_out && !tx_fault_out)
        else $error("fault pin still pulled low during fault");

    // With the pin low at two edges in a row no toggle can be pending
    AST_FAULT_HOLDS: assert property (fault_ff && !pin_dis && $past(!pin_dis) |=> fault_ff)
        else $error("fault dropped without release");

    AST_TOGGLE_CLEARS: assert property (
        s_fault_latched ##1 s_pin_released |=> !fault_ff)
        else $error("disable toggle did not clear fault");

    AST_STATUS_FAULT: assert property (
        hits_ctl(reg_addr_in) |=> reg_rdata_out[TFL_BIT_TX_FAULT] == $past(fault_ff))
        else $error("status byte fault bit wrong");

    AST_EYE_SAFE: assert property (eye_unsafe_in |=> !laser_en_ff)
        else $error("laser on while eye monitor unsafe");

    AST_LOS_PIN: assert property (rx_unusable_in |=> optical_signal_lost_out)
        else $error("signal-lost pin not raised");

    AST_STATUS_LOS: assert property (
        hits_ctl(reg_addr_in) |=> reg_rdata_out[TFL_BIT_SIG_LOST] == $past(los_ff))
        else $error("status byte signal-lost bit wrong");

    AST_DISABLE_OR: assert property (pin_dis |=> !laser_en_ff)
        else $error("laser on while disabled");

    AST_SOFT_OFF: assert property (soft_dis_ff |-> !laser_en_ff)
        else $error("laser on while software disable set");

    AST_UNDRIVEN: assert property (!tx_disable_driven_in |=> !laser_en_ff)
        else $error("undriven disable not treated as asserted");

    AST_PERSIST: assert property (fault_cause |=> fault_ff ##0 !laser_en_ff)
        else $error("persisting fault released");

endmodule : tfl_fault_los

/* logic/tfl_pkg.sv */
// Constants and types for the transceiver fault and signal-loss status block
package tfl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TFL_CTL_STATUS_OFS = 8'h6e;
    localparam int         TFL_BIT_DIS_STATE  = 7;
    localparam int         TFL_BIT_SOFT_DIS   = 6;
    localparam int         TFL_BIT_TX_FAULT   = 2;
    localparam int         TFL_BIT_SIG_LOST   = 1;
    localparam logic       TFL_SOFT_DIS_RST   = 1'b0;
    localparam logic [7:0] TFL_RDATA_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Host timing (spacing between disable assertions)
    // ------------------------------------------------------------
    localparam int TFL_CLK_MHZ       = 50;
    localparam int TFL_DIS_GAP_MS    = 10;
    localparam int TFL_DIS_GAP_CYC   = TFL_DIS_GAP_MS * 1000 * TFL_CLK_MHZ;

    // ------------------------------------------------------------
    // Control and status byte layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic       dis_state;
        logic       soft_dis;
        logic [2:0] rsvd_hi;
        logic       tx_fault;
        logic       sig_lost;
        logic       rsvd_lo;
    } tfl_ctl_status_s;

endpackage : tfl_pkg

/* sim/tfl_host_model.sv */
// Host board model that drives the transmit-disable pin
`timescale 1ns/1ps

module tfl_host_model (
    // Clock and requests from the bench
    input  wire logic clk_sys_in,
    input  wire logic dis_req_in,
    input  wire logic float_req_in,
    // Disable pin towards the module
    output logic      tx_disable_out        = 1'b1,
    output logic      tx_disable_driven_out = 1'b0
);
    logic dis_req_q   = 1'b0;
    logic float_req_q = 1'b1;

    // Requests are taken on the rising edge so the pin never races the bench
    always @(posedge clk_sys_in) begin
        dis_req_q   <= dis_req_in;
        float_req_q <= float_req_in;
    end

    // Pin moves just after the falling edge; an open pin reads high
    always @(negedge clk_sys_in) begin
        tx_disable_driven_out <= !float_req_q;
        tx_disable_out        <= float_req_q | dis_req_q;
    end
endmodule : tfl_host_model

/* sim/tfl_fault_los_tb_top.sv */
// Self-checking bench for the fault latch and signal-loss status block
`timescale 1ns/1ps

module tfl_fault_los_tb_top;
    import tfl_pkg::*;
    logic       clk_sys_in = 1'b0, rst_n_in = 1'b0, dis_req = 1'b0, float_req = 1'b1;
    logic       fault_in = 1'b0, eye_in = 1'b0, rx_bad = 1'b0, wr = 1'b0;
    logic       tx_dis, tx_drv, f_out, f_oe, los, laser;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    int         n_errors = 0, cmp_count = 0, cyc = 0;

    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    tfl_host_model i_host (.clk_sys_in(clk_sys_in), .dis_req_in(dis_req),
        .float_req_in(float_req), .tx_disable_out(tx_dis), .tx_disable_driven_out(tx_drv));

    tfl_fault_los i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .tx_disable_in(tx_dis), .tx_disable_driven_in(tx_drv), .laser_fault_in(fault_in),
        .eye_unsafe_in(eye_in), .rx_unusable_in(rx_bad), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .tx_fault_out(f_out),
        .tx_fault_oe_out(f_oe), .optical_signal_lost_out(los), .laser_enable_out(laser));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc_n

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        cyc_n(1);
        chk("status byte", rdata, exp);
    endtask : rd

    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc_n(1);
        wr = 1'b0;
        cyc_n(1);
    endtask : wr_byte

    task automatic pin(input logic d, input logic f);
        dis_req = d;
        float_req = f;
        cyc_n(2);
    endtask : pin

    task automatic t_open_pin();
        cyc_n(3);
        chk("laser", laser, 0);
        rd(TFL_CTL_STATUS_OFS, 8'h80);
        pin(0, 0);
        chk("laser", laser, 1);
        chk("fault oe", f_oe, 1);
        pin(1, 0);
        chk("laser", laser, 0);
        pin(0, 0);
    endtask : t_open_pin

    task automatic t_soft();
        wr_byte(TFL_CTL_STATUS_OFS, 8'hff);
        chk("laser", laser, 0);
        wr_byte(8'h6f, 8'h00);
        rd(TFL_CTL_STATUS_OFS, 8'hc0);
        rd(8'h6f, TFL_RDATA_UNMAPPED);
        wr_byte(TFL_CTL_STATUS_OFS, 8'h00);
        chk("laser", laser, 1);
    endtask : t_soft

    task automatic t_fault(input logic eye);
        fault_in = !eye;
        eye_in = eye;
        cyc_n(1);
        fault_in = 1'b0;
        eye_in = 1'b0;
        chk("laser", laser, 0);
        cyc_n(3);
        chk("fault oe", f_oe, 0);
        chk("fault data", f_out, 0);
        rd(TFL_CTL_STATUS_OFS, 8'h04);
        wr_byte(TFL_CTL_STATUS_OFS, 8'h40);
        wr_byte(TFL_CTL_STATUS_OFS, 8'h00);
        chk("fault oe", f_oe, 0);
        pin(1, 0);
        pin(0, 0);
        cyc_n(1);
        chk("fault oe", f_oe, 1);
        chk("laser", laser, 1);
    endtask : t_fault

    task automatic t_los();
        rx_bad = 1'b1;
        cyc_n(1);
        chk("signal lost", los, 1);
        rd(TFL_CTL_STATUS_OFS, 8'h02);
        rx_bad = 1'b0;
        cyc_n(1);
        chk("signal lost", los, 0);
    endtask : t_los

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Cut a hang short
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        cyc_n(4);
        chk("fault oe", f_oe, 1);
        rst_n_in = 1'b1;
        t_open_pin();
        t_soft();
        t_fault(1'b0);
        t_fault(1'b1);
        t_los();
        fault_in = 1'b1;
        cyc_n(1);
        chk("fault oe", f_oe, 0);
        fault_in = 1'b0;
        rst_n_in = 1'b0;
        cyc_n(1);
        rst_n_in = 1'b1;
        cyc_n(1);
        chk("fault oe", f_oe, 1);
        end_sim();
    end
endmodule : tfl_fault_los_tb_top
